// File: logic/hdlc_ctrl_pkg.sv
// Constants and types for the packet controller control/status block
// Function
// - Rising edge of rx codeword reset bit resets codeword detector once.
// - Rising edge of rx packet reset bit resets receive packet controller.
// - Flag/idle select picks 7Eh (zero) or FFh (one) between packets.
// - Rising edge of tx reset bit resets tx packet and codeword logic.
// - Rising edge of abort flushes tx FIFO, sends one FEh, then fill.
// - Software sets end of message; hardware clears it after last byte.
// - Zero stuff defeat one disables zero insertion over internal enable.
// - CRC defeat zero appends CRC; one suppresses CRC generation.
// - Codeword change bit sets on any detect/no-code transition.
// - Packet end sets on valid finish, CRC error, overrun or abort.
// - Packet start sets when opening byte of a message is detected.
// - Rx half full sets when 64-byte rx FIFO passes its midpoint.
// - Rx not empty sets while rx FIFO holds at least one byte.
// - Tx half empty sets when 64-byte tx FIFO drains below midpoint.
// - Tx not full sets while tx FIFO has room for one byte.
// - Tx message end sets when a message finished transmitting.
// - Event bits latch and clear on read; FIFO level bits are live.
// - Mask bit per status position; zero masks, one enables interrupt.
// - Unmasked event pulls interrupt low until its status bit is read.
// - Status write selects bits to update and clear; others hold.
package hdlc_ctrl_pkg;

  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned CNT_W  = 7;

  localparam logic [ADDR_W-1:0] PACKET_CONTROL_OFF = 8'h00;
  localparam logic [ADDR_W-1:0] PACKET_STATUS_OFF  = 8'h01;
  localparam logic [ADDR_W-1:0] PACKET_INT_MASK_OFF = 8'h02;

  localparam logic [DATA_W-1:0] REG_RESET  = 8'h00;
  localparam logic [DATA_W-1:0] FLAG_BYTE  = 8'h7e;
  localparam logic [DATA_W-1:0] IDLE_BYTE  = 8'hff;
  localparam logic [DATA_W-1:0] ABORT_BYTE = 8'hfe;

  localparam logic [CNT_W-1:0] FIFO_DEPTH = 7'h40;
  localparam logic [CNT_W-1:0] FIFO_HALF  = 7'h20;
  localparam logic [CNT_W-1:0] FIFO_NONE  = 7'h00;

  // Status bit positions, shared with the mask register
  localparam int unsigned ST_CODEWORD_CHANGE = 7;
  localparam int unsigned ST_PACKET_END      = 6;
  localparam int unsigned ST_PACKET_START    = 5;
  localparam int unsigned ST_RX_HALF_FULL    = 4;
  localparam int unsigned ST_RX_NOT_EMPTY    = 3;
  localparam int unsigned ST_TX_HALF_EMPTY   = 2;
  localparam int unsigned ST_TX_NOT_FULL     = 1;
  localparam int unsigned ST_TX_MESSAGE_END  = 0;

  // One marks a latched event bit, zero a live level bit
  localparam logic [DATA_W-1:0] STATUS_LATCHED = 8'he1;

  typedef struct packed {
    logic rx_codeword_reset;
    logic rx_packet_reset;
    logic tx_flag_idle_select;
    logic tx_packet_reset;
    logic tx_abort;
    logic tx_end_of_message;
    logic tx_zero_stuff_defeat;
    logic tx_crc_defeat;
  } packet_control_t;

  typedef struct packed {
    logic valid_msg;
    logic crc_error;
    logic overrun;
    logic abort_seen;
    logic opening_byte;
  } rx_events_t;

  typedef enum logic [1:0] {
    FILL_NORMAL = 2'b00,
    FILL_ABORT  = 2'b01
  } fill_state_t;

endpackage : hdlc_ctrl_pkg

// File: logic/status_capture.sv
// Per-bit status capture with write-selected read update and clear
`timescale 1ns/10ps
module status_capture
  import hdlc_ctrl_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              nrst,
  input  wire logic [DATA_W-1:0] cause,
  input  wire logic              sel_wr,
  input  wire logic [DATA_W-1:0] sel_mask,
  output logic      [DATA_W-1:0] pending,
  output logic      [DATA_W-1:0] read_q
);

  logic [DATA_W-1:0] held_q;
  wire  [DATA_W-1:0] held_d;
  wire  [DATA_W-1:0] read_d;
  wire  [DATA_W-1:0] cur_w;
  wire  [DATA_W-1:0] take_w;

  for (genvar i = 0; i < DATA_W; i++) begin : g_bit
    assign take_w[i] = sel_wr && sel_mask[i];
    assign cur_w[i]  = STATUS_LATCHED[i] ? held_q[i] : cause[i];
    // A new event in the clearing cycle survives the clear
    assign held_d[i] = STATUS_LATCHED[i] &&
                       (cause[i] || (held_q[i] && !take_w[i]));
    assign read_d[i] = take_w[i] ? cur_w[i] : read_q[i];
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      held_q <= REG_RESET;
      read_q <= REG_RESET;
    end else begin
      held_q <= held_d;
      read_q <= read_d;
    end
  end

  assign pending = cur_w;

endmodule : status_capture

// File: logic/hdlc_bit_code_control_status.sv
// Control, status and mask registers of the packet controller
`timescale 1ns/10ps
module hdlc_bit_code_control_status
  import hdlc_ctrl_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              nrst,
  // Host register port
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  input  wire logic [DATA_W-1:0] reg_wdata,
  output logic      [DATA_W-1:0] reg_rdata,
  output logic                   int_n,
  // Receive side status from the controller core
  input  wire logic              codeword_detected,
  input  wire rx_events_t        rx_events,
  input  wire logic [CNT_W-1:0]  rx_fifo_count,
  // Transmit side status from the controller core
  input  wire logic [CNT_W-1:0]  tx_fifo_count,
  input  wire logic              tx_fifo_write,
  input  wire logic              tx_last_byte_sent,
  input  wire logic              tx_message_done,
  input  wire logic              tx_fill_taken,
  input  wire logic              zero_stuff_enable_int,
  // Control outputs to the controller core
  output logic                   rx_codeword_reset,
  output logic                   rx_packet_reset,
  output logic                   tx_packet_reset,
  output logic                   tx_codeword_reset,
  output logic                   tx_fifo_flush,
  output logic      [DATA_W-1:0] tx_fill_byte,
  output logic                   tx_end_of_message,
  output logic                   tx_zero_stuff_en,
  output logic                   tx_crc_en
);

  packet_control_t   ctrl_q;
  packet_control_t   ctrl_d;
  packet_control_t   ctrl_prev_q;
  logic [DATA_W-1:0] mask_q;
  logic              detect_prev_q;
  fill_state_t       fill_q;
  fill_state_t       fill_d;
  logic [DATA_W-1:0] fill_byte_d;
  logic [DATA_W-1:0] rdata_d;
  logic [DATA_W-1:0] status_cause;
  logic [DATA_W-1:0] status_pending;
  logic [DATA_W-1:0] status_read;
  logic              rx_cw_rst_q;
  logic              rx_pkt_rst_q;
  logic              tx_rst_q;
  logic              flush_q;

  // Address decode
  wire hit_ctrl_w   = (reg_addr == PACKET_CONTROL_OFF);
  wire hit_status_w = (reg_addr == PACKET_STATUS_OFF);
  wire hit_mask_w   = (reg_addr == PACKET_INT_MASK_OFF);
  wire wr_ctrl_w    = reg_wr && hit_ctrl_w;
  wire wr_status_w  = reg_wr && hit_status_w;
  wire wr_mask_w    = reg_wr && hit_mask_w;

  // Edge detect on the self-arming control bits
  wire rx_cw_edge_w  = ctrl_q.rx_codeword_reset &&
                       !ctrl_prev_q.rx_codeword_reset;
  wire rx_pkt_edge_w = ctrl_q.rx_packet_reset &&
                       !ctrl_prev_q.rx_packet_reset;
  wire tx_rst_edge_w = ctrl_q.tx_packet_reset &&
                       !ctrl_prev_q.tx_packet_reset;
  wire abort_edge_w  = ctrl_q.tx_abort && !ctrl_prev_q.tx_abort;

  // Control register next value
  always_comb begin
    ctrl_d = ctrl_q;
    if (tx_last_byte_sent) begin
      ctrl_d.tx_end_of_message = 1'b0;
    end
    // Software write wins so a fresh set for the next packet is not lost
    if (wr_ctrl_w) begin
      ctrl_d = packet_control_t'(reg_wdata);
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      ctrl_q      <= packet_control_t'(REG_RESET);
      ctrl_prev_q <= packet_control_t'(REG_RESET);
    end else begin
      ctrl_q      <= ctrl_d;
      ctrl_prev_q <= ctrl_q;
    end
  end

  // Mask register, same bit order as the status register
  always_ff @(posedge clk) begin
    if (!nrst) begin
      mask_q <= REG_RESET;
    end else if (wr_mask_w) begin
      mask_q <= reg_wdata;
    end
  end

  // One-cycle reset pulses, one per rising edge only
  // A bit left high never pulses again; software writes zero to re-arm
  always_ff @(posedge clk) begin
    if (!nrst) begin
      rx_cw_rst_q <= 1'b0;
    end else begin
      rx_cw_rst_q <= rx_cw_edge_w;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      rx_pkt_rst_q <= 1'b0;
    end else begin
      rx_pkt_rst_q <= rx_pkt_edge_w;
    end
  end

  // One pulse serves both transmit resets so they never drift apart
  always_ff @(posedge clk) begin
    if (!nrst) begin
      tx_rst_q <= 1'b0;
    end else begin
      tx_rst_q <= tx_rst_edge_w;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      flush_q <= 1'b0;
    end else begin
      flush_q <= abort_edge_w;
    end
  end

  assign rx_codeword_reset = rx_cw_rst_q;
  assign rx_packet_reset   = rx_pkt_rst_q;
  assign tx_packet_reset   = tx_rst_q;
  assign tx_codeword_reset = tx_rst_q;
  assign tx_fifo_flush     = flush_q;

  // Fill byte sequencer: one abort byte, then flag or idle
  always_comb begin
    fill_d = fill_q;
    case (fill_q)
      FILL_NORMAL: begin
        if (abort_edge_w) begin
          fill_d = FILL_ABORT;
        end
      end
      FILL_ABORT: begin
        // New data or the abort byte having gone out ends the abort
        if (tx_fill_taken || tx_fifo_write) begin
          fill_d = FILL_NORMAL;
        end
      end
      default: begin
        fill_d = FILL_NORMAL;
      end
    endcase
    if (tx_rst_edge_w) begin
      fill_d = FILL_NORMAL;
    end
  end

  wire [DATA_W-1:0] between_w = ctrl_q.tx_flag_idle_select ?
                                IDLE_BYTE : FLAG_BYTE;

  assign fill_byte_d = (fill_d == FILL_ABORT) ? ABORT_BYTE : between_w;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      fill_q <= FILL_NORMAL;
    end else begin
      fill_q <= fill_d;
    end
  end

  // Registered so the byte is steady for a whole transmit slot
  always_ff @(posedge clk) begin
    if (!nrst) begin
      tx_fill_byte <= FLAG_BYTE;
    end else begin
      tx_fill_byte <= fill_byte_d;
    end
  end

  // Packet option outputs
  assign tx_end_of_message = ctrl_q.tx_end_of_message;
  assign tx_zero_stuff_en  = zero_stuff_enable_int &&
                             !ctrl_q.tx_zero_stuff_defeat;
  assign tx_crc_en         = !ctrl_q.tx_crc_defeat;

  // Status causes
  always_ff @(posedge clk) begin
    if (!nrst) begin
      detect_prev_q <= 1'b0;
    end else begin
      detect_prev_q <= codeword_detected;
    end
  end

  wire cw_change_w  = codeword_detected ^ detect_prev_q;
  wire pkt_end_w    = rx_events.valid_msg || rx_events.crc_error ||
                      rx_events.overrun || rx_events.abort_seen;
  wire rx_half_w    = (rx_fifo_count > FIFO_HALF);
  wire rx_ne_w      = (rx_fifo_count != FIFO_NONE);
  wire tx_half_w    = (tx_fifo_count < FIFO_HALF);
  wire tx_nf_w      = (tx_fifo_count < FIFO_DEPTH);

  always_comb begin
    status_cause                     = '0;
    status_cause[ST_CODEWORD_CHANGE] = cw_change_w;
    status_cause[ST_PACKET_END]      = pkt_end_w;
    status_cause[ST_PACKET_START]    = rx_events.opening_byte;
    status_cause[ST_RX_HALF_FULL]    = rx_half_w;
    status_cause[ST_RX_NOT_EMPTY]    = rx_ne_w;
    status_cause[ST_TX_HALF_EMPTY]   = tx_half_w;
    status_cause[ST_TX_NOT_FULL]     = tx_nf_w;
    status_cause[ST_TX_MESSAGE_END]  = tx_message_done;
  end

  status_capture u_status (
    .clk      (clk),
    .nrst     (nrst),
    .cause    (status_cause),
    .sel_wr   (wr_status_w),
    .sel_mask (reg_wdata),
    .pending  (status_pending),
    .read_q   (status_read)
  );

  // Interrupt released once the latched cause is read and cleared
  wire irq_w = |(status_pending & mask_q);

  always_ff @(posedge clk) begin
    if (!nrst) begin
      int_n <= 1'b1;
    end else begin
      int_n <= !irq_w;
    end
  end

  // Read words per register; unmapped offsets read zero
  wire [DATA_W-1:0] ctrl_word_w   = DATA_W'(ctrl_q);
  wire [DATA_W-1:0] status_word_w = status_read;
  wire [DATA_W-1:0] mask_word_w   = mask_q;

  assign rdata_d = hit_ctrl_w   ? ctrl_word_w :
                   hit_status_w ? status_word_w :
                   hit_mask_w   ? mask_word_w : REG_RESET;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      reg_rdata <= REG_RESET;
    end else if (reg_rd) begin
      reg_rdata <= rdata_d;
    end
  end

endmodule : hdlc_bit_code_control_status

// File: bench/hdlc_core_model.sv
// Far-side core model: tx FIFO occupancy and fill byte pacing
`timescale 1ns/10ps
module hdlc_core_model
  import hdlc_ctrl_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             nrst,
  input  wire logic             tx_fifo_write,
  input  wire logic             tx_fifo_flush,
  input  wire logic             tx_packet_reset,
  output logic      [CNT_W-1:0] tx_fifo_count,
  output logic                  tx_fill_taken,
  output logic                  zero_stuff_enable_int
);
  logic [3:0] slot_q;
  // Slow link: a fill byte leaves every eight cycles
  assign tx_fill_taken         = slot_q[2:0] == 3'h7;
  assign zero_stuff_enable_int = slot_q[3];
  always_ff @(posedge clk) begin
    if (!nrst) begin
      slot_q        <= 4'h0;
      tx_fifo_count <= FIFO_NONE;
    end else begin
      slot_q <= slot_q + 4'h1;
      if (tx_fifo_flush || tx_packet_reset)
        tx_fifo_count <= FIFO_NONE;
      else if (tx_fifo_write && tx_fifo_count != FIFO_DEPTH)
        tx_fifo_count <= tx_fifo_count + 7'h01;
    end
  end
endmodule : hdlc_core_model

// File: bench/hdlc_bit_code_control_status_asserts.sv
// Checker for control pulses, fill byte, enables and interrupt
`timescale 1ns/10ps
module hdlc_bit_code_control_status_asserts
  import hdlc_ctrl_pkg::*;
(
  input wire logic              clk,
  input wire logic              nrst,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic              reg_wr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic              int_n,
  input wire logic              tx_message_done,
  input wire logic              tx_last_byte_sent,
  input wire logic              tx_end_of_message,
  input wire logic              zero_stuff_enable_int,
  input wire logic              rx_codeword_reset,
  input wire logic              rx_packet_reset,
  input wire logic              tx_packet_reset,
  input wire logic              tx_codeword_reset,
  input wire logic              tx_fifo_flush,
  input wire logic [DATA_W-1:0] tx_fill_byte,
  input wire logic              tx_zero_stuff_en,
  input wire logic              tx_crc_en
);
  logic [DATA_W-1:0] ctl_q;
  logic [DATA_W-1:0] msk_q;
  wire wr_ctl = reg_wr && reg_addr == PACKET_CONTROL_OFF;
  wire wr_msk = reg_wr && reg_addr == PACKET_INT_MASK_OFF;
  // Shadow of host writes; bit 2 untracked, hardware clears it
  always_ff @(posedge clk) begin
    if (!nrst) begin
      ctl_q <= REG_RESET;
      msk_q <= REG_RESET;
    end else begin
      if (wr_ctl)
        ctl_q <= reg_wdata;
      if (wr_msk)
        msk_q <= reg_wdata;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence one_pulse(s);
    s ##1 !s;
  endsequence
  sequence abort_start;
    (tx_fifo_flush && tx_fill_byte == ABORT_BYTE) ##1 !tx_fifo_flush;
  endsequence
  a_rx_cw_reset: assert property (
    $rose(ctl_q[7]) |=> one_pulse(rx_codeword_reset))
    else $error("Codeword reset pulse missing");
  a_rx_pkt_quiet: assert property (
    !$rose(ctl_q[6]) |=> !rx_packet_reset)
    else $error("Packet reset without rising bit");
  a_rx_pkt_reset: assert property (
    $rose(ctl_q[6]) |=> one_pulse(rx_packet_reset))
    else $error("Packet reset pulse missing");
  a_eom_set: assert property (
    wr_ctl && reg_wdata[2] |=> tx_end_of_message)
    else $error("End of message not set");
  a_eom_clear: assert property (
    tx_last_byte_sent && !wr_ctl |=> !tx_end_of_message)
    else $error("End of message not cleared");
  a_tx_reset_pair: assert property (
    $rose(ctl_q[4]) |=> one_pulse(tx_packet_reset && tx_codeword_reset))
    else $error("Tx reset pulses wrong");
  a_abort_fill: assert property (
    $rose(ctl_q[3]) |=> abort_start)
    else $error("Abort flush or byte missing");
  a_fill_select: assert property (
    $stable(ctl_q[5]) && tx_fill_byte != ABORT_BYTE |->
      tx_fill_byte == (ctl_q[5] ? IDLE_BYTE : FLAG_BYTE))
    else $error("Wrong fill byte");
  a_zero_stuff: assert property (
    tx_zero_stuff_en == (zero_stuff_enable_int && !ctl_q[1]))
    else $error("Zero stuff enable wrong");
  a_crc_defeat: assert property (
    tx_crc_en == !ctl_q[0])
    else $error("CRC enable wrong");
  a_int_raise: assert property (
    tx_message_done && msk_q[0] && !wr_msk |-> ##2 !int_n)
    else $error("Interrupt not raised");
  a_int_masked: assert property (
    $past(msk_q) == REG_RESET && msk_q == REG_RESET |-> int_n)
    else $error("Interrupt while all masked");
endmodule : hdlc_bit_code_control_status_asserts
bind hdlc_bit_code_control_status
  hdlc_bit_code_control_status_asserts chk_i (.*);

// File: bench/test_hdlc_bit_code_control_status.sv
// Self-checking bench for the packet control and status registers
`timescale 1ns/10ps
module test_hdlc_bit_code_control_status
  import hdlc_ctrl_pkg::*;
;
  logic              clk = 1'b0;
  logic              nrst = 1'b0;
  logic [ADDR_W-1:0] reg_addr = 8'h00;
  logic              reg_wr = 1'b0;
  logic              reg_rd = 1'b0;
  logic [DATA_W-1:0] reg_wdata = 8'h00;
  logic [DATA_W-1:0] reg_rdata;
  logic              int_n;
  logic              codeword_detected = 1'b0;
  rx_events_t        rx_events = '0;
  logic [CNT_W-1:0]  rx_fifo_count = 7'h00;
  logic [CNT_W-1:0]  tx_fifo_count;
  logic              tx_fifo_write = 1'b0;
  logic              tx_last_byte_sent = 1'b0;
  logic              tx_message_done = 1'b0;
  logic              tx_fill_taken, zero_stuff_enable_int;
  logic              tx_fifo_flush, tx_packet_reset;
  logic [DATA_W-1:0] exp_q[$];
  logic [DATA_W-1:0] cpy = 8'h00;
  logic [DATA_W-1:0] r;
  int                miscompares = 0;
  int                checks = 0;
  int                seed = 32'ha9c1;
  hdlc_bit_code_control_status hdlc_bit_code_control_status_i (
    .clk, .nrst, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
    .int_n, .codeword_detected, .rx_events, .rx_fifo_count,
    .tx_fifo_count, .tx_fifo_write, .tx_last_byte_sent, .tx_message_done,
    .tx_fill_taken, .zero_stuff_enable_int, .rx_codeword_reset(),
    .rx_packet_reset(), .tx_packet_reset, .tx_codeword_reset(),
    .tx_fifo_flush, .tx_fill_byte(), .tx_end_of_message(),
    .tx_zero_stuff_en(), .tx_crc_en());
  hdlc_core_model hdlc_core_model_i (
    .clk, .nrst, .tx_fifo_write, .tx_fifo_flush, .tx_packet_reset,
    .tx_fifo_count, .tx_fill_taken, .zero_stuff_enable_int);
  always #2 clk = ~clk;
  task automatic cmp(input string n, input logic [7:0] e, s);
    checks++;
    if (s !== e) begin
      miscompares++;
      $display("FAIL %s expected %h seen %h", n, e, s);
    end
  endtask : cmp
  // One op per two cycles keeps strobes from being driven twice at once
  task automatic bus(input logic w, input logic [7:0] a, d);
    @(negedge clk);
    reg_wr = w;
    reg_rd = !w;
    reg_addr = a;
    reg_wdata = d;
    if (!w)
      exp_q.push_back(d);
    @(negedge clk);
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  endtask : bus
  task automatic stat(input logic [7:0] sel, now);
    bus(1'b1, PACKET_STATUS_OFF, sel);
    cpy = (cpy & ~sel) | (now & sel);
    bus(1'b0, PACKET_STATUS_OFF, cpy);
  endtask : stat
  task automatic ev(input rx_events_t e, input logic cw, logic [2:0] t);
    @(negedge clk);
    rx_events = e;
    codeword_detected = cw;
    {tx_fifo_write, tx_last_byte_sent, tx_message_done} = t;
    @(negedge clk);
    rx_events = '0;
    {tx_fifo_write, tx_last_byte_sent, tx_message_done} = 3'h0;
  endtask : ev
  task automatic print_verdict;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : print_verdict
  always @(posedge clk) begin
    if (reg_rd === 1'b1) begin
      @(negedge clk);
      cmp("reg_rdata", exp_q.pop_front(), reg_rdata);
    end
  end
  initial begin
    #40000;
    miscompares++;
    print_verdict();
  end
  initial begin
    repeat (10) @(posedge clk);
    @(negedge clk);
    nrst = 1'b1;
    for (int a = 0; a < 4; a++)
      bus(1'b0, a[7:0], REG_RESET);
    for (int b = 0; b < 8; b++) begin
      r = 8'h01 << b;
      bus(1'b1, PACKET_CONTROL_OFF, r);
      bus(1'b1, PACKET_CONTROL_OFF, r);
      bus(1'b0, PACKET_CONTROL_OFF, r);
      bus(1'b1, PACKET_CONTROL_OFF, 8'h00);
    end
    repeat (4) begin
      r = 8'($random(seed)) & 8'h23;
      bus(1'b1, PACKET_CONTROL_OFF, r);
      bus(1'b0, PACKET_CONTROL_OFF, r);
      r = 8'($random(seed));
      bus(1'b1, PACKET_INT_MASK_OFF, r);
      bus(1'b0, PACKET_INT_MASK_OFF, r);
    end
    bus(1'b1, PACKET_CONTROL_OFF, 8'h04);
    ev('0, 1'b0, 3'h2);
    bus(1'b0, PACKET_CONTROL_OFF, 8'h00);
    bus(1'b1, PACKET_INT_MASK_OFF, 8'h01);
    ev('0, 1'b0, 3'h1);
    stat(8'h01, 8'h01);
    stat(8'h01, 8'h00);
    rx_fifo_count = 7'h21;
    ev(5'h1f, 1'b1, 3'h1);
    stat(8'hff, 8'hff);
    stat(8'hff, 8'h1e);
    rx_fifo_count = 7'h20;
    stat(8'h10, 8'h00);
    for (int i = 0; i < 5; i++) begin
      ev(rx_events_t'(5'h01 << i), 1'b0, 3'h0);
      stat(8'h60, i == 0 ? 8'h20 : 8'h40);
    end
    stat(8'h80, 8'h80);
    repeat (31) ev('0, 1'b0, 3'h4);
    stat(8'h04, 8'h04);
    ev('0, 1'b0, 3'h4);
    stat(8'h04, 8'h00);
    repeat (33) ev('0, 1'b0, 3'h4);
    stat(8'h02, 8'h00);
    bus(1'b1, PACKET_CONTROL_OFF, 8'h08);
    repeat (3) @(negedge clk);
    stat(8'h06, 8'h06);
    // Let the last read compare finish before the verdict
    repeat (2) @(negedge clk);
    if (exp_q.size() != 0)
      miscompares++;
    print_verdict();
  end
endmodule : test_hdlc_bit_code_control_status
